// >>> logic/cpt_map.vh
// Register map, field positions, reset values and timing for the coupled PWM pair timer
// Contract
// - Run set: status on edge one, count edge two
// - Plain coupled: count equals duty1 drops output1
// - Count equals duty2 drops output2, both modes
// - Plain coupled: count equals period2 raises output2
// - One-shot period match: output1 high, zero, stop
// - Repeat period match: output1 high, zero, continue
// - Period match reloads all duty, period buffers
// - Setting run after one-shot starts new cycle
// - Run cleared: one more edge, then status zero
// - Restart continues from held count, no clearing
// - Counter byte write zeroes count, output1 high
// - Stopped: duty, period writes load buffers directly
// - Control zero picks clock, event point, polarity1
// - Output2 polarity has its own control bit
// - External pin may start, stop or clear
// - Period is period1 plus one count clocks
// - Output2 delays are duty2+1 and period2+1
// - First event may slip one clock, then fixed
// - Dead-time enable uses duty2 as dead-time
// - Dead-time: duty1 plus duty2 match drops output1
// - Dead-time: duty1 match raises output2
`ifndef CPT_MAP_VH
`define CPT_MAP_VH
// Byte addresses of the word registers
`define CPT_A_CTRL0    8'h00
`define CPT_A_CTRL1    8'h04
`define CPT_A_TRIG     8'h08
`define CPT_A_CTRL7    8'h0c
`define CPT_A_CNT_LO   8'h10
`define CPT_A_CNT_HI   8'h14
`define CPT_A_DUTY1    8'h18
`define CPT_A_PER1     8'h1c
`define CPT_A_DUTY2    8'h20
`define CPT_A_PER2     8'h24
`define CPT_A_STATUS   8'h28
// First control zero fields
`define CPT_F_CKSEL_LO 0
`define CPT_F_CKSEL_HI 2
`define CPT_F_EVPT     3
`define CPT_F_POL1     4
`define CPT_F_ONESHOT  5
`define CPT_F_COUPLED  6
`define CPT_F_DTEN     7
// First control one fields
`define CPT_F_RUN      0
`define CPT_F_STAT     1
// Trigger control fields
`define CPT_F_TMODE_LO 0
`define CPT_F_TMODE_HI 1
`define CPT_F_TEDGE_LO 2
`define CPT_F_TEDGE_HI 3
`define CPT_F_TPIN     4
// Trigger modes
`define CPT_TM_SOFT    2'h0
`define CPT_TM_LEVEL   2'h1
`define CPT_TM_START   2'h2
`define CPT_TM_CLEAR   2'h3
// Reset values
`define CPT_RST_PER    16'hffff
`define CPT_RST_DUTY   16'h0000
`define CPT_RST_CNT    16'h0000
`define CPT_CNT_ONE    16'h0001
`define CPT_SYNC_DEPTH 2
`endif

// >>> logic/cpt_sync.v
// Two-stage synchroniser for asynchronous level inputs
module cpt_sync #(
  parameter W = 2
) (
  sys_clk,
  rst,
  d_in,
  q_out
);
  input  wire         sys_clk; // System clock
  input  wire         rst;     // Asynchronous reset
  input  wire [W-1:0] d_in;    // Raw pin levels
  output wire [W-1:0] q_out;   // Synchronised levels

  reg [W-1:0] meta_r;          // First stage, read only by second
  reg [W-1:0] sync_r;          // Second stage

  // Two flops in series
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule

// >>> logic/cpt_timer.v
// Coupled two-channel PWM timer with APB register access
//
// Design decisions made here: register access over APB and the register addresses.
`include "cpt_map.vh"
module cpt_timer (
  sys_clk,
  rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  trig_pin,
  pwm_out1,
  pwm_out2,
  period_event
);
  input  wire        sys_clk;      // System clock, 20 MHz
  input  wire        rst;          // Asynchronous reset, high
  input  wire        psel;         // APB select
  input  wire        penable;      // APB enable
  input  wire        pwrite;       // APB direction
  input  wire [7:0]  paddr;        // APB byte address
  input  wire [31:0] pwdata;       // APB write data
  output wire [31:0] prdata;       // APB read data
  output wire        pready;       // APB ready
  output wire        pslverr;      // APB error
  input  wire [1:0]  trig_pin;     // External trigger pins
  output wire        pwm_out1;     // First channel output
  output wire        pwm_out2;     // Second channel output
  output wire        period_event; // Event pulse at chosen point

  // Configuration registers
  reg [7:0]  ctrl0_r;       // Clock, event point, polarity, modes
  reg [4:0]  trig_r;        // Trigger mode, edge, pin select
  reg        pol2_r;        // Second output polarity
  reg        run_r;         // Run bit
  reg        stat_r;        // Counter status flag
  reg [15:0] cnt_r;         // Shared counter
  reg [15:0] duty1_r;       // Programmed first duty
  reg [15:0] per1_r;        // Programmed first period
  reg [15:0] duty2_r;       // Programmed second duty / dead-time
  reg [15:0] per2_r;        // Programmed second period
  reg [15:0] duty1_buf_r;   // First duty buffer
  reg [15:0] per1_buf_r;    // First period buffer
  reg [15:0] duty2_buf_r;   // Second duty buffer
  reg [15:0] per2_buf_r;    // Second period buffer
  reg        flag1_r;       // First output flag
  reg        flag2_r;       // Second output flag
  reg        out1_r;        // Registered first output
  reg        out2_r;        // Registered second output
  reg        event_r;       // Registered event pulse
  reg [7:0]  div_r;         // Count clock prescaler
  reg        trig_d_r;      // Previous trigger level
  reg [31:0] rdata_r;       // Read data captured in setup
  reg        err_r;         // Error captured in setup

  // Decoded fields
  wire [2:0] cksel     = ctrl0_r[`CPT_F_CKSEL_HI:`CPT_F_CKSEL_LO];
  wire       ev_at_duty = ctrl0_r[`CPT_F_EVPT];
  wire       pol1      = ctrl0_r[`CPT_F_POL1];
  wire       one_shot  = ctrl0_r[`CPT_F_ONESHOT];
  wire       coupled   = ctrl0_r[`CPT_F_COUPLED];
  wire       dt_en     = ctrl0_r[`CPT_F_DTEN];
  wire [1:0] tmode     = trig_r[`CPT_F_TMODE_HI:`CPT_F_TMODE_LO];
  wire       tedge_lo  = trig_r[`CPT_F_TEDGE_LO];
  wire       tpin      = trig_r[`CPT_F_TPIN];

  // Bus phases
  wire setup_ph = psel & ~penable;
  wire acc_wr   = psel & penable & pwrite;

  // Per-register write strobes
  wire wr_ctrl0 = acc_wr & (paddr == `CPT_A_CTRL0);
  wire wr_ctrl1 = acc_wr & (paddr == `CPT_A_CTRL1);
  wire wr_trig  = acc_wr & (paddr == `CPT_A_TRIG);
  wire wr_ctrl7 = acc_wr & (paddr == `CPT_A_CTRL7);
  wire wr_cnt   = acc_wr & ((paddr == `CPT_A_CNT_LO) | (paddr == `CPT_A_CNT_HI));
  wire wr_duty1 = acc_wr & (paddr == `CPT_A_DUTY1);
  wire wr_per1  = acc_wr & (paddr == `CPT_A_PER1);
  wire wr_duty2 = acc_wr & (paddr == `CPT_A_DUTY2);
  wire wr_per2  = acc_wr & (paddr == `CPT_A_PER2);

  // Synchronised trigger pins
  wire [1:0] trig_sync;

  cpt_sync #(
    .W (2)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d_in    (trig_pin),
    .q_out   (trig_sync)
  );

  // Trigger level, normalised so high means start level
  wire trig_raw   = tpin ? trig_sync[1] : trig_sync[0];
  wire trig_lvl   = tedge_lo ? trig_raw : ~trig_raw;
  wire trig_start = trig_lvl & ~trig_d_r;
  wire trig_stop  = ~trig_lvl & trig_d_r;

  // Level mode gates the run bit with the pin level
  wire run_eff = run_r & ((tmode != `CPT_TM_LEVEL) | trig_lvl);

  // Count clock tick: divide sys_clk by two to the cksel
  wire [7:0] div_mask = ~(8'hff << cksel);
  wire       tick     = ((div_r & div_mask) == div_mask);

  // Counter advances on a tick while operating, or on the tail tick
  wire step = tick & stat_r;
  wire per_match = (cnt_r == per1_buf_r);
  wire [15:0] dt_sum = duty1_buf_r + duty2_buf_r;
  // Stopped counter: writes feed buffers at once
  wire stopped = ~run_r & ~stat_r;
  // External clear events
  wire ext_clr = ((tmode == `CPT_TM_LEVEL) & trig_stop)
               | ((tmode == `CPT_TM_CLEAR) & trig_start);

  // Prescaler runs freely
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Trigger edge history
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // Idle level of the default setting: no false edge after reset
      trig_d_r <= 1'b1;
    end else begin
      trig_d_r <= trig_lvl;
    end
  end

  // Configuration registers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl0_r <= 8'h00;
      trig_r  <= 5'h00;
      pol2_r  <= 1'b0;
      duty1_r <= `CPT_RST_DUTY;
      per1_r  <= `CPT_RST_PER;
      duty2_r <= `CPT_RST_DUTY;
      per2_r  <= `CPT_RST_PER;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_r <= pwdata[7:0];
      end
      if (wr_trig) begin
        trig_r <= pwdata[4:0];
      end
      if (wr_ctrl7) begin
        pol2_r <= pwdata[0];
      end
      if (wr_duty1) begin
        duty1_r <= pwdata[15:0];
      end
      if (wr_per1) begin
        per1_r <= pwdata[15:0];
      end
      if (wr_duty2) begin
        duty2_r <= pwdata[15:0];
      end
      if (wr_per2) begin
        per2_r <= pwdata[15:0];
      end
    end
  end

  // Run bit: software and trigger set it, one-shot end clears it
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
    end else if (wr_ctrl1) begin
      // Software write wins over a same-cycle auto clear
      run_r <= pwdata[`CPT_F_RUN];
    end else if ((tmode == `CPT_TM_START) & trig_start) begin
      run_r <= 1'b1;
    end else if (step & per_match & one_shot & run_r) begin
      run_r <= 1'b0;
    end
  end

  // Status flag: up on first tick after run, down after tail tick
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_r <= 1'b0;
    end else if (tick) begin
      // One-shot end drops status together with run
      if (stat_r & per_match & one_shot & run_r) begin
        stat_r <= 1'b0;
      end else if (run_eff) begin
        stat_r <= 1'b1;
      end else begin
        stat_r <= 1'b0;
      end
    end
  end

  // Shared counter
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= `CPT_RST_CNT;
    end else if (wr_cnt | ext_clr) begin
      // Byte write or external clear wins over counting
      cnt_r <= `CPT_RST_CNT;
    end else if (step) begin
      if (per_match) begin
        cnt_r <= `CPT_RST_CNT;
      end else begin
        cnt_r <= cnt_r + `CPT_CNT_ONE;
      end
    end
  end

  // Buffers: reload at period match, or direct while stopped
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      duty1_buf_r <= `CPT_RST_DUTY;
      per1_buf_r  <= `CPT_RST_PER;
      duty2_buf_r <= `CPT_RST_DUTY;
      per2_buf_r  <= `CPT_RST_PER;
    end else if (step & per_match) begin
      // Period match reload beats direct loads
      duty1_buf_r <= duty1_r;
      per1_buf_r  <= per1_r;
      duty2_buf_r <= duty2_r;
      per2_buf_r  <= per2_r;
    end else if (stopped) begin
      if (wr_duty1) begin
        duty1_buf_r <= pwdata[15:0];
      end
      if (wr_per1) begin
        per1_buf_r <= pwdata[15:0];
      end
      if (wr_duty2) begin
        duty2_buf_r <= pwdata[15:0];
      end
      if (wr_per2) begin
        per2_buf_r <= pwdata[15:0];
      end
    end
  end

  // First output flag
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag1_r <= 1'b1;
    end else if (wr_cnt | ext_clr) begin
      flag1_r <= 1'b1;
    end else if (step) begin
      if (per_match) begin
        flag1_r <= 1'b1;
      end else if (dt_en & coupled) begin
        if (cnt_r == dt_sum) begin
          flag1_r <= 1'b0;
        end
      end else if (cnt_r == duty1_buf_r) begin
        flag1_r <= 1'b0;
      end
    end
  end

  // Second output flag, driven only in coupled mode
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag2_r <= 1'b0;
    end else if (step & coupled) begin
      if (dt_en) begin
        // Duty1 match raises, dead-time match drops
        if (cnt_r == duty1_buf_r) begin
          flag2_r <= 1'b1;
        end else if (cnt_r == duty2_buf_r) begin
          flag2_r <= 1'b0;
        end
      end else begin
        // Period2 match raises, duty2 match drops
        if (cnt_r == per2_buf_r) begin
          flag2_r <= 1'b1;
        end else if (cnt_r == duty2_buf_r) begin
          flag2_r <= 1'b0;
        end
      end
    end
  end

  // Registered pin drivers with polarity and event pulse
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out1_r  <= 1'b0;
      out2_r  <= 1'b0;
      event_r <= 1'b0;
    end else begin
      // Outputs lag the flags by one cycle
      out1_r  <= flag1_r ^ pol1;
      out2_r  <= flag2_r ^ pol2_r;
      // Event at period match, or at duty match when chosen
      event_r <= step & (ev_at_duty ? (cnt_r == duty1_buf_r) : per_match);
    end
  end

  // Read mux captured during setup so data comes from flops
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h00000000;
      err_r   <= 1'b0;
    end else if (setup_ph) begin
      // Answer stands in rdata_r through the access phase
      err_r <= 1'b0;
      case (paddr)
        `CPT_A_CTRL0:  rdata_r <= {24'h000000, ctrl0_r};
        `CPT_A_CTRL1:  rdata_r <= {30'h00000000, stat_r, run_r};
        `CPT_A_TRIG:   rdata_r <= {27'h0000000, trig_r};
        `CPT_A_CTRL7:  rdata_r <= {31'h00000000, pol2_r};
        `CPT_A_CNT_LO: rdata_r <= {24'h000000, cnt_r[7:0]};
        `CPT_A_CNT_HI: rdata_r <= {24'h000000, cnt_r[15:8]};
        `CPT_A_DUTY1:  rdata_r <= {16'h0000, duty1_r};
        `CPT_A_PER1:   rdata_r <= {16'h0000, per1_r};
        `CPT_A_DUTY2:  rdata_r <= {16'h0000, duty2_r};
        `CPT_A_PER2:   rdata_r <= {16'h0000, per2_r};
        `CPT_A_STATUS: rdata_r <= {30'h00000000, flag2_r, flag1_r};
        default: begin
          // Unmapped address answers with error and zero data
          rdata_r <= 32'h00000000;
          err_r   <= 1'b1;
        end
      endcase
    end
  end

  // Zero-wait slave
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & err_r;
  assign prdata       = rdata_r;
  assign pwm_out1     = out1_r;
  assign pwm_out2     = out2_r;
  assign period_event = event_r;
endmodule

// >>> verification/cpt_timer_assertions.sv
// Pin-level property checker for the coupled PWM pair timer
`include "cpt_map.vh"
module cpt_timer_assertions (
  input wire        sys_clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        pwm_out1,
  input wire        period_event
);
  logic [7:0]  ctl_r;  // Shadow of control zero
  logic [15:0] per_r;  // Shadow of period one
  logic [1:0]  tm_r;   // Shadow of trigger mode
  logic [23:0] wage_r; // Cycles since last write
  logic [23:0] gap_r;  // Cycles since last event
  wire         wr_acc = psel & penable & pwrite; // Write lands now
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Shadows and spacing counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_r  <= 8'h00;
      per_r  <= 16'hffff;
      tm_r   <= 2'h0;
      wage_r <= 24'h0;
      gap_r  <= 24'h0;
    end else begin
      gap_r  <= period_event ? 24'h1 : gap_r + 24'h1;
      wage_r <= wr_acc ? 24'h0 : wage_r + 24'h1;
      if (wr_acc && paddr == `CPT_A_CTRL0) ctl_r <= pwdata[7:0];
      if (wr_acc && paddr == `CPT_A_PER1) per_r <= pwdata[15:0];
      if (wr_acc && paddr == `CPT_A_TRIG) tm_r <= pwdata[1:0];
    end
  end
  sequence s_cnt_write;
    wr_acc && (paddr == `CPT_A_CNT_LO || paddr == `CPT_A_CNT_HI);
  endsequence
  sequence s_quiet_event;
    period_event && !ctl_r[3] && tm_r == 2'h0 && wage_r > gap_r + 24'h3;
  endsequence
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("ready low in access phase");
  a_unmapped_err: assert property (psel && penable && paddr > `CPT_A_STATUS |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && penable && paddr <= `CPT_A_STATUS
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on a mapped access");
  a_unmapped_zero: assert property (psel && penable && !pwrite
    && paddr > `CPT_A_STATUS |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_event_single: assert property (period_event |=> !period_event)
    else $error("event pulse longer than one cycle");
  a_event_spacing: assert property (s_quiet_event |->
    gap_r == ({8'h0, per_r} + 24'h1) << ctl_r[2:0])
    else $error("event spacing differs from period");
  a_clear_out1: assert property (s_cnt_write |-> ##2 pwm_out1 == !ctl_r[4])
    else $error("output one not active after counter write");
  a_clear_no_event: assert property (s_cnt_write ##0 !ctl_r[3] |-> ##3 !period_event)
    else $error("period event right after counter clear");
endmodule
bind cpt_timer cpt_timer_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwm_out1(pwm_out1), .period_event(period_event));

// >>> verification/cpt_pin_model.sv
// Far-side model: external trigger pins, moved just after a clock edge
module cpt_pin_model (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [1:0]  trig_lvl,
  output logic [1:0] trig_pin
);
  // Pins follow the wanted levels one edge later, low in reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_pin <= 2'h0;
    end else begin
      trig_pin <= trig_lvl;
    end
  end
endmodule

// >>> verification/cpt_timer_tb_top.sv
// Self-checking bench for the coupled PWM pair timer
`include "cpt_map.vh"
module cpt_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;  // 20 MHz clock
  logic        rst = 1'b1;      // Reset, high
  logic        psel = 1'b0;     // Bus select
  logic        penable = 1'b0;  // Bus enable
  logic        pwrite = 1'b0;   // Bus direction
  logic [7:0]  paddr = 8'h00;   // Bus address
  logic [31:0] pwdata = 32'h0;  // Bus write data
  logic [1:0]  trig_lvl = 2'h0; // Wanted trigger levels
  wire  [31:0] prdata;
  wire         pready, pslverr, pwm_out1, pwm_out2, period_event;
  wire  [1:0]  trig_pin;
  logic [31:0] rd;              // Last read data
  logic        rerr;            // Last error response
  logic [15:0] c, c2;           // Counter snapshots
  logic        pl1, pl2;        // Output polarities
  integer      seed = 32'h319d6395;
  int          errors = 0, total_checks = 0, cyc = 0;
  int          i, dt, ck, p, d1, d2, p2, w, h1, h2, ev;
  cpt_timer u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_pin(trig_pin), .pwm_out1(pwm_out1), .pwm_out2(pwm_out2),
    .period_event(period_event));
  cpt_pin_model u_pins (.sys_clk(sys_clk), .rst(rst), .trig_lvl(trig_lvl),
    .trig_pin(trig_pin));
  always #25 sys_clk = ~sys_clk;
  // Cycle ceiling against a hang
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus transfer: setup, then access held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll control one until the given bit reads zero
  task automatic wait_stat(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, `CPT_A_CTRL1, 32'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 200);
    chk(rd[b], 0);
  endtask
  task automatic rdcnt(output logic [15:0] v);
    apb(1'b0, `CPT_A_CNT_LO, 32'h0);
    v[7:0] = rd[7:0];
    apb(1'b0, `CPT_A_CNT_HI, 32'h0);
    v[15:8] = rd[7:0];
  endtask
  // High cycles of each output and events over n cycles
  task automatic measure(input int n);
    h1 = 0;
    h2 = 0;
    ev = 0;
    repeat (n) begin
      @(posedge sys_clk);
      h1 += (pwm_out1 === 1'b1);
      h2 += (pwm_out2 === 1'b1);
      ev += (period_event === 1'b1);
    end
  endtask
  // High cycles per period expected on an output
  function automatic int exp_hi(input int ch, input logic pl);
    int t;
    t = ch == 1 ? (dt ? d1 + d2 + 1 : d1 + 1) : (dt ? p - d1 + d2 + 1 : p - p2 + d2 + 1);
    t = t << ck;
    return pl ? w - t : t;
  endfunction
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `CPT_A_PER1, 32'h0);
    chk(rd, {16'h0, `CPT_RST_PER});
    apb(1'b1, 8'h2c, 32'hffffffff);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 8'h2c, 32'h0);
    chk(rd, 32'h0);
    $display("Test registers done");
    // Coupled repeat runs, plain and dead-time, random settings
    for (i = 0; i < 6; i++) begin
      dt = i % 2;
      ck = $random(seed) & 1;
      p = 8 + ($random(seed) & 15);
      d1 = i == 0 ? 0 : 3 + ($random(seed) & 3);
      d2 = $random(seed) & 1;
      p2 = d2 + 1 + ($random(seed) & 3);
      pl1 = 1'($random(seed));
      pl2 = 1'($random(seed));
      w = (p + 1) << ck;
      apb(1'b1, `CPT_A_CTRL0, {24'h0, 1'(dt), 2'b10, pl1, 1'(i / 3), 3'(ck)});
      apb(1'b1, `CPT_A_CTRL7, {31'h0, pl2});
      apb(1'b1, `CPT_A_DUTY1, 32'(d1));
      apb(1'b1, `CPT_A_PER1, 32'(p));
      apb(1'b1, `CPT_A_DUTY2, 32'(d2));
      apb(1'b1, `CPT_A_PER2, 32'(p2));
      apb(1'b1, `CPT_A_CNT_LO, 32'h0);
      apb(1'b1, `CPT_A_CTRL1, 32'h1);
      repeat (2 * w + 8) @(posedge sys_clk);
      measure(w);
      chk(h1, exp_hi(1, pl1));
      chk(h2, exp_hi(2, pl2));
      chk(ev, 1);
      apb(1'b1, `CPT_A_CTRL1, 32'h0);
      wait_stat(1);
    end
    $display("Test coupled modes done");
    apb(1'b1, `CPT_A_CTRL0, 32'h40);
    apb(1'b1, `CPT_A_PER1, 32'h0fff);
    apb(1'b1, `CPT_A_CNT_HI, 32'h0);
    rdcnt(c);
    chk(c, 0);
    apb(1'b0, `CPT_A_STATUS, 32'h0);
    chk(rd[0], 1);
    apb(1'b1, `CPT_A_CTRL1, 32'h1);
    repeat (100) @(posedge sys_clk);
    apb(1'b1, `CPT_A_CTRL1, 32'h0);
    wait_stat(1);
    rdcnt(c);
    chk(c > 16'd60, 1);
    repeat (20) @(posedge sys_clk);
    rdcnt(c2);
    chk(c2, c);
    apb(1'b1, `CPT_A_CTRL1, 32'h1);
    apb(1'b1, `CPT_A_CTRL1, 32'h0);
    wait_stat(1);
    rdcnt(c2);
    chk(c2 > c && c2 - c < 16'd9, 1);
    $display("Test stop and resume done");
    apb(1'b1, `CPT_A_CTRL0, 32'h60);
    apb(1'b1, `CPT_A_PER1, 32'h5);
    apb(1'b1, `CPT_A_CNT_LO, 32'h0);
    apb(1'b1, `CPT_A_CTRL1, 32'h1);
    wait_stat(0);
    rdcnt(c);
    chk(c, 0);
    apb(1'b1, `CPT_A_CTRL1, 32'h1);
    repeat (2) @(posedge sys_clk);
    rdcnt(c);
    chk(c != 16'h0, 1);
    wait_stat(0);
    $display("Test one-shot done");
    apb(1'b1, `CPT_A_CTRL0, 32'h40);
    apb(1'b1, `CPT_A_TRIG, 32'h6);
    trig_lvl <= 2'h1;
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `CPT_A_CTRL1, 32'h0);
    chk(rd[0], 1);
    apb(1'b1, `CPT_A_TRIG, 32'h5);
    trig_lvl <= 2'h0;
    repeat (8) @(posedge sys_clk);
    rdcnt(c);
    chk(c, 0);
    // Clear on start edge, second pin selected
    apb(1'b1, `CPT_A_TRIG, 32'h17);
    apb(1'b1, `CPT_A_CTRL1, 32'h0);
    wait_stat(1);
    apb(1'b1, `CPT_A_PER1, 32'h0fff);
    apb(1'b1, `CPT_A_CTRL1, 32'h1);
    repeat (40) @(posedge sys_clk);
    trig_lvl <= 2'h2;
    repeat (8) @(posedge sys_clk);
    rdcnt(c);
    chk(c < 16'd20, 1);
    $display("Test trigger done");
    tally_and_finish();
  end
endmodule
